// >>> pkg/rpsl_defs.svh
// Constants for the repeater packet statistics logger
`ifndef RPSL_DEFS_SVH
`define RPSL_DEFS_SVH
`define RPSL_ID_W 4
`define RPSL_LEN_W 12
`define RPSL_RUNT_MAX 12'h08D
`define RPSL_GOOD_MIN 12'h090
`define RPSL_LEN_MAX 12'hFFF
`define RPSL_LEN_ONE 12'h001
`define RPSL_FIFO_DEPTH 16
`endif

// >>> pkg/rpsl_pkg.sv
// Types shared by the statistics logger files
`include "rpsl_defs.svh"
package rpsl_pkg;
    typedef enum logic [1:0] {KIND_NONE, KIND_RUNT, KIND_GOOD, KIND_COLL} rpsl_kind_e;
    // Raw per-packet record gathered on the link clock
    typedef struct packed {
        logic [`RPSL_ID_W-1:0] id;
        logic [`RPSL_LEN_W-1:0] len;
        logic coll;
        logic symerr;
    } rpsl_rec_s;
    // Classified update handed to counter storage
    typedef struct packed {
        logic [`RPSL_ID_W-1:0] port;
        rpsl_kind_e kind;
        logic [`RPSL_LEN_W-1:0] len;
        logic symerr;
    } rpsl_stat_s;
endpackage

// >>> rtl/rpsl_fifo.sv
// Synchronous flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module rpsl_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    // Full and empty come straight from the occupancy count
    assign in_ready_out = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid_out = (cnt_r != '0);
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign out_data_out = mem_r[rd_r];

    // Storage, written only on an accepted push
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_r[wr_r] <= in_data_in;
        end
    end

    // Pointers wrap at DEPTH, which need not be a power of two
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + AW'(1);
            end
            if (pop) begin
                rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + AW'(1);
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// >>> rtl/rpsl_link.sv
// Link-side capture of one packet record per management bus frame
`timescale 1ns/1ps
`include "rpsl_defs.svh"
module rpsl_link (
    input wire logic mgmt_bus_clock_in,
    input wire logic resetn_in,
    input wire logic mgmt_data_valid_n_in,
    input wire logic [`RPSL_ID_W-1:0] mgmt_nibble_in,
    input wire logic mgmt_error_n_in,
    input wire logic mgmt_collision_n_in,
    output rpsl_pkg::rpsl_rec_s rec_out,
    output logic rec_toggle_out
);
    logic rst_s1_r;
    logic rst_s2_r;
    logic active_r;
    rpsl_pkg::rpsl_rec_s acc_r;
    logic dv;

    // Reset brought into the link domain; it only acts while the clock runs
    always_ff @(posedge mgmt_bus_clock_in) begin
        rst_s1_r <= resetn_in;
        rst_s2_r <= rst_s1_r;
    end

    assign dv = !mgmt_data_valid_n_in;

    // Accumulate the frame; the first nibble carries the source id
    always_ff @(posedge mgmt_bus_clock_in) begin
        if (!rst_s2_r) begin
            active_r <= 1'b0;
            acc_r <= '0;
        end else if (dv && !active_r) begin
            active_r <= 1'b1;
            acc_r.id <= mgmt_nibble_in;
            acc_r.len <= `RPSL_LEN_ONE;
            acc_r.coll <= !mgmt_collision_n_in;
            acc_r.symerr <= !mgmt_error_n_in;
        end else if (dv) begin
            // Saturate so jabber frames stay oversize
            if (acc_r.len != `RPSL_LEN_MAX) begin
                acc_r.len <= acc_r.len + `RPSL_LEN_ONE;
            end
            acc_r.coll <= acc_r.coll | !mgmt_collision_n_in;
            acc_r.symerr <= acc_r.symerr | !mgmt_error_n_in;
        end else begin
            active_r <= 1'b0;
        end
    end

    // Record held stable until the next frame ends, then the toggle flips
    always_ff @(posedge mgmt_bus_clock_in) begin
        if (!rst_s2_r) begin
            rec_out <= '0;
            rec_toggle_out <= 1'b0;
        end else if (!dv && active_r) begin
            rec_out <= acc_r;
            rec_toggle_out <= !rec_toggle_out;
        end
    end

    chk_id_latch: assert property (@(posedge mgmt_bus_clock_in) disable iff (!rst_s2_r)
        (dv && !active_r) |=> (acc_r.id == $past(mgmt_nibble_in)))
        else $error("source id not latched from first nibble");
endmodule

// >>> rtl/rpsl_top.sv
// Packet statistics logger: link capture, crossing, FIFO and classifier
`timescale 1ns/1ps
`include "rpsl_defs.svh"
module rpsl_top #(
    parameter int FIFO_DEPTH = `RPSL_FIFO_DEPTH
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic mgmt_bus_clock_in,
    input wire logic mgmt_data_valid_n_in,
    input wire logic [`RPSL_ID_W-1:0] mgmt_nibble_in,
    input wire logic mgmt_error_n_in,
    input wire logic mgmt_collision_n_in,
    input wire logic mgmt_mode_in,
    input wire logic stat_ready_in,
    output logic stat_valid_out,
    output rpsl_pkg::rpsl_stat_s stat_out,
    output logic overrun_out,
    output logic [1:0] stale_flags_out
);
    localparam int RW = $bits(rpsl_pkg::rpsl_rec_s);

    rpsl_pkg::rpsl_rec_s link_rec;
    logic link_tog;
    logic tog_s1_r;
    logic tog_s2_r;
    logic tog_s3_r;
    logic mode_s1_r;
    logic mode_q_r;
    logic rec_evt;
    rpsl_pkg::rpsl_rec_s pend_r;
    logic pend_v_r;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [RW-1:0] fifo_out_bits;
    rpsl_pkg::rpsl_rec_s head;
    logic head_ready;
    logic pop;
    logic stale_coll_r;
    logic stale_err_r;
    logic coll_eff;
    logic err_eff;
    logic stat_valid_r;
    rpsl_pkg::rpsl_stat_s stat_r;
    logic overrun_r;

    // Class of a packet from its length and collision flag
    function automatic rpsl_pkg::rpsl_kind_e classify(
        input logic [`RPSL_LEN_W-1:0] len,
        input logic coll
    );
        if (coll) begin
            classify = rpsl_pkg::KIND_COLL;
        end else if (len <= `RPSL_RUNT_MAX) begin
            classify = rpsl_pkg::KIND_RUNT;
        end else if (len >= `RPSL_GOOD_MIN) begin
            classify = rpsl_pkg::KIND_GOOD;
        end else begin
            classify = rpsl_pkg::KIND_NONE;
        end
    endfunction

    // Long enough for a symbol-error count: valid, oversize or jabber
    function automatic logic counts_symerr(input logic [`RPSL_LEN_W-1:0] len);
        counts_symerr = (len >= `RPSL_GOOD_MIN);
    endfunction

    // Link-clock capture; spurious bus activity is filtered outside
    rpsl_link u_link (
        .mgmt_bus_clock_in(mgmt_bus_clock_in),
        .resetn_in(resetn_in),
        .mgmt_data_valid_n_in(mgmt_data_valid_n_in),
        .mgmt_nibble_in(mgmt_nibble_in),
        .mgmt_error_n_in(mgmt_error_n_in),
        .mgmt_collision_n_in(mgmt_collision_n_in),
        .rec_out(link_rec),
        .rec_toggle_out(link_tog)
    );

    // Toggle crossing; only the second stage and later are looked at
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            tog_s1_r <= 1'b0;
            tog_s2_r <= 1'b0;
            tog_s3_r <= 1'b0;
        end else begin
            tog_s1_r <= link_tog;
            tog_s2_r <= tog_s1_r;
            tog_s3_r <= tog_s2_r;
        end
    end

    // One pulse for each record that has crossed
    assign rec_evt = tog_s2_r ^ tog_s3_r;

    // Mode pin comes from software logic on another clock
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            mode_s1_r <= 1'b0;
            mode_q_r <= 1'b0;
        end else begin
            mode_s1_r <= mgmt_mode_in;
            mode_q_r <= mode_s1_r;
        end
    end

    // One-deep holding slot in front of the FIFO; it absorbs a stall
    // Record bits are stable here because the link holds them a whole frame
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            pend_r <= '0;
            pend_v_r <= 1'b0;
        end else if (rec_evt && (!pend_v_r || fifo_in_ready)) begin
            pend_r <= link_rec;
            pend_v_r <= 1'b1;
        end else if (fifo_in_ready) begin
            pend_v_r <= 1'b0;
        end
    end

    // A record lost to back-pressure is flagged, never silently merged
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            overrun_r <= 1'b0;
        end else if (rec_evt && pend_v_r && !fifo_in_ready) begin
            overrun_r <= 1'b1;
        end
    end

    rpsl_fifo #(
        .WIDTH(RW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .in_valid_in(pend_v_r),
        .in_ready_out(fifo_in_ready),
        .in_data_in(pend_r),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(head_ready),
        .out_data_out(fifo_out_bits)
    );

    // Storage back-pressure stalls the FIFO drain
    assign head = rpsl_pkg::rpsl_rec_s'(fifo_out_bits);
    assign head_ready = !stat_valid_r || stat_ready_in;
    assign pop = fifo_out_valid && head_ready;

    // Leftover flags mix into the next packet classified
    assign coll_eff = head.coll | stale_coll_r;
    assign err_eff = head.symerr | stale_err_r;

    // Leftover state: built outside the mode, spent by the first logged packet
    // Mode entry itself touches nothing here, which is why the miscount exists
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            stale_coll_r <= 1'b0;
            stale_err_r <= 1'b0;
        end else if (pop && mode_q_r) begin
            stale_coll_r <= 1'b0;
            stale_err_r <= 1'b0;
        end else if (pop) begin
            stale_coll_r <= coll_eff;
            stale_err_r <= err_eff;
        end
    end

    // Update toward counter storage, emitted only in management mode
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            stat_valid_r <= 1'b0;
            stat_r <= '0;
        end else if (pop && mode_q_r) begin
            stat_valid_r <= 1'b1;
            stat_r.port <= head.id;
            stat_r.kind <= classify(head.len, coll_eff);
            stat_r.len <= head.len;
            stat_r.symerr <= err_eff && counts_symerr(head.len);
        end else if (stat_ready_in) begin
            stat_valid_r <= 1'b0;
        end
    end

    // Registered state straight to the outputs
    assign stat_valid_out = stat_valid_r;
    assign stat_out = stat_r;
    assign overrun_out = overrun_r;
    assign stale_flags_out = {stale_coll_r, stale_err_r};

    // All checks below run on the system clock and rest during reset
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);

    // Leftover flags move only when a packet is popped
    chk_stale_kept: assert property (
        !pop |=> $stable(stale_coll_r) && $stable(stale_err_r))
        else $error("leftover flags changed without a packet");

    // Mode entry by itself must not wipe the leftover flags
    chk_mode_entry: assert property (
        $rose(mode_q_r) && !pop |=> $stable(stale_coll_r) && $stable(stale_err_r))
        else $error("mode entry disturbed the leftover flags");

    // Packets outside the mode build up the leftover flags
    chk_stale_built: assert property (
        pop && !mode_q_r |=>
            (stale_coll_r == $past(coll_eff)) && (stale_err_r == $past(err_eff)))
        else $error("leftover flags not built from an unlogged packet");

    // The first logged packet spends the leftover flags
    chk_stale_spent: assert property (
        pop && mode_q_r |=> !stale_coll_r && !stale_err_r)
        else $error("leftover flags survived a logged packet");

    // A leftover collision shows up on the first logged packet
    chk_first_miscount: assert property (
        pop && mode_q_r && stale_coll_r |=>
            stat_valid_r && (stat_r.kind == rpsl_pkg::KIND_COLL))
        else $error("leftover collision did not reach the first packet");

    // With no leftover collision a packet reports its own collision state
    chk_later_correct: assert property (
        pop && mode_q_r && !stale_coll_r |=>
            (stat_r.kind == rpsl_pkg::KIND_COLL) == $past(head.coll))
        else $error("clean packet collision class wrong");

    // Storage location follows the latched source id
    chk_port_source: assert property (
        pop && mode_q_r |=> stat_r.port == $past(head.id))
        else $error("update port differs from latched id");

    // Length is handed over unchanged with each update
    chk_len_passed: assert property (
        pop && mode_q_r |=> stat_r.len == $past(head.len))
        else $error("update length differs from the record");

    // An update waits unchanged until storage takes it
    chk_update_held: assert property (
        stat_valid_r && !stat_ready_in |=> stat_valid_r && $stable(stat_r))
        else $error("pending update changed before it was taken");

    // Symbol errors count only for valid or longer packets
    chk_symerr_count: assert property (
        pop && mode_q_r |=> stat_r.symerr == ($past(err_eff) &&
            ($past(head.len) >= `RPSL_GOOD_MIN)))
        else $error("symbol error flag wrong for packet length");

    // Saturated jabber length still counts its symbol errors
    chk_symerr_jabber: assert property (
        pop && mode_q_r && err_eff && (head.len == `RPSL_LEN_MAX) |=> stat_r.symerr)
        else $error("symbol error in jabber frame not counted");

    // Short activity without collision is a runt
    chk_runt_kind: assert property (
        pop && mode_q_r && !coll_eff && (head.len <= `RPSL_RUNT_MAX) |=>
            stat_r.kind == rpsl_pkg::KIND_RUNT)
        else $error("short packet not logged as runt");

    // No runt is ever logged above the limit
    chk_runt_limit: assert property (
        stat_valid_r && (stat_r.kind == rpsl_pkg::KIND_RUNT) |->
            stat_r.len <= `RPSL_RUNT_MAX)
        else $error("runt logged above the runt limit");

    // The gap between runt and minimum good frame is logged as neither
    chk_none_gap: assert property (
        pop && mode_q_r && !coll_eff && (head.len > `RPSL_RUNT_MAX) &&
            (head.len < `RPSL_GOOD_MIN) |=> stat_r.kind == rpsl_pkg::KIND_NONE)
        else $error("gap length packet logged as runt or good");

    // No good frame is ever logged below the minimum
    chk_good_min: assert property (
        stat_valid_r && (stat_r.kind == rpsl_pkg::KIND_GOOD) |->
            stat_r.len >= `RPSL_GOOD_MIN)
        else $error("good frame logged below minimum size");

    // Packets popped outside the mode leave storage alone
    chk_mode_gate: assert property (
        pop && !mode_q_r |=> !stat_valid_r ##1 !stat_valid_r || mode_q_r)
        else $error("storage updated outside management mode");

    // A held record is never overwritten while the FIFO is full
    chk_slot_hold: assert property (
        pend_v_r && !fifo_in_ready |=> pend_v_r && $stable(pend_r))
        else $error("held record changed while the FIFO was full");

    // A record that finds no room raises the loss flag
    chk_overrun_set: assert property (
        rec_evt && pend_v_r && !fifo_in_ready |=> overrun_r)
        else $error("lost record not flagged");

    // The loss flag stays up until reset
    chk_overrun_sticky: assert property (
        overrun_r |=> overrun_r)
        else $error("loss flag cleared without reset");
endmodule

// >>> sim/rpsl_ctrl_model.sv
// Behavioural repeater controller driving the management bus
`timescale 1ns/1ps
`include "rpsl_defs.svh"
module rpsl_ctrl_model (
    output logic mgmt_bus_clock_out,
    output logic mgmt_data_valid_n_out,
    output logic [`RPSL_ID_W-1:0] mgmt_nibble_out,
    output logic mgmt_error_n_out,
    output logic mgmt_collision_n_out
);
    // Bus idle, link clock parked low between frames
    initial begin
        mgmt_bus_clock_out = 1'b0;
        mgmt_data_valid_n_out = 1'b1;
        mgmt_nibble_out = 4'h0;
        mgmt_error_n_out = 1'b1;
        mgmt_collision_n_out = 1'b1;
    end
    // One link period; lines only move while the clock is low
    task automatic tick();
        #62.5 mgmt_bus_clock_out = 1'b1;
        #62.5 mgmt_bus_clock_out = 1'b0;
    endtask
    // Released nibble wanders so a stale value cannot pass for data
    task automatic idle(input int n);
        repeat (n) begin
            mgmt_data_valid_n_out = 1'b1;
            mgmt_error_n_out = 1'b1;
            mgmt_collision_n_out = 1'b1;
            mgmt_nibble_out = ~mgmt_nibble_out;
            tick();
        end
    endtask
    // Valid rises only inside a qualified frame; first nibble is the source id
    task automatic frame(input logic [3:0] id, input int len, input bit coll, input int err_at);
        for (int i = 0; i < len; i++) begin
            mgmt_data_valid_n_out = 1'b0;
            mgmt_nibble_out = (i == 0) ? id : i[3:0];
            mgmt_error_n_out = (i != err_at);
            mgmt_collision_n_out = !(coll && i == len / 2);
            tick();
        end
        idle(3);
    endtask
endmodule

// >>> sim/rpsl_top_bench.sv
// Self-checking bench for the packet statistics logger
`timescale 1ns/1ps
module rpsl_top_bench;
    logic clk_in, resetn_in, mgmt_mode_in, stat_ready_in;
    logic lclk, dv_n, err_n, coll_n, stat_valid_out, overrun_out;
    logic [3:0] nib;
    logic [1:0] stale_flags_out;
    rpsl_pkg::rpsl_stat_s stat_out;
    int num_errors = 0;
    int checks = 0;

    rpsl_top #(.FIFO_DEPTH(16)) rpsl_top_inst (
        .clk_in(clk_in), .resetn_in(resetn_in), .mgmt_bus_clock_in(lclk),
        .mgmt_data_valid_n_in(dv_n), .mgmt_nibble_in(nib), .mgmt_error_n_in(err_n),
        .mgmt_collision_n_in(coll_n), .mgmt_mode_in(mgmt_mode_in),
        .stat_ready_in(stat_ready_in), .stat_valid_out(stat_valid_out),
        .stat_out(stat_out), .overrun_out(overrun_out), .stale_flags_out(stale_flags_out)
    );
    rpsl_ctrl_model rpsl_ctrl_model_inst (
        .mgmt_bus_clock_out(lclk), .mgmt_data_valid_n_out(dv_n), .mgmt_nibble_out(nib),
        .mgmt_error_n_out(err_n), .mgmt_collision_n_out(coll_n)
    );

    // 20 MHz system clock
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    task automatic close_out();
        if (num_errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Flag and count comparison
    task automatic chk_val(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    // Whole update record comparison
    task automatic chk_stat(input rpsl_pkg::rpsl_stat_s exp);
        checks++;
        if (stat_out !== exp) begin
            num_errors++;
            $display("BAD stat_out expected %0h seen %0h", exp, stat_out);
        end
    endtask

    // Wait bounded for an update, judge it, then take it with a one-cycle ready
    task automatic get_stat(input logic [3:0] id, input int k, input int len, input bit sym);
        rpsl_pkg::rpsl_stat_s exp;
        int n;
        exp = '{port: id, kind: rpsl_pkg::rpsl_kind_e'(k),
                len: (len > 4095) ? 12'hFFF : len[11:0], symerr: sym};
        n = 0;
        // Frames end on link edges; realign to the stimulus edge first
        @(negedge clk_in);
        while (stat_valid_out !== 1'b1) begin
            @(negedge clk_in);
            if (++n > 80) begin
                num_errors++;
                close_out();
            end
        end
        chk_stat(exp);
        stat_ready_in = 1'b1;
        @(negedge clk_in);
        stat_ready_in = 1'b0;
    endtask

    task automatic t_reset();
        chk_val("stat_valid_out", 16'h0000, stat_valid_out);
        chk_val("overrun_out", 16'h0000, overrun_out);
        chk_val("stale_flags_out", 16'h0000, stale_flags_out);
    endtask

    // Length boundaries, symbol errors in long and jabber frames, collision
    task automatic t_classify();
        int lens[8] = '{141, 142, 143, 144, 144, 300, 4100, 150};
        int errs[8] = '{3, -1, -1, -1, 100, 5, 4000, -1};
        int kinds[8] = '{1, 0, 0, 2, 2, 2, 2, 3};
        bit syms[8] = '{0, 0, 0, 0, 1, 1, 1, 0};
        for (int i = 0; i < 8; i++) begin
            rpsl_ctrl_model_inst.frame(4'(i + 8), lens[i], i == 7, errs[i]);
            get_stat(4'(i + 8), kinds[i], lens[i], syms[i]);
        end
    endtask

    // Collision outside the mode, re-entry, then two valid packets
    task automatic t_mode();
        mgmt_mode_in = 1'b0;
        repeat (4) @(negedge clk_in);
        rpsl_ctrl_model_inst.frame(4'h2, 150, 1'b1, 10);
        repeat (30) @(negedge clk_in);
        chk_val("stat_valid_out", 16'h0000, stat_valid_out);
        chk_val("stale_flags_out", 16'h0003, stale_flags_out);
        mgmt_mode_in = 1'b1;
        repeat (10) @(negedge clk_in);
        chk_val("stale_flags_out", 16'h0003, stale_flags_out);
        rpsl_ctrl_model_inst.frame(4'h3, 150, 1'b0, -1);
        get_stat(4'h3, 3, 150, 1'b1);
        chk_val("stale_flags_out", 16'h0000, stale_flags_out);
        rpsl_ctrl_model_inst.frame(4'h4, 150, 1'b0, -1);
        get_stat(4'h4, 2, 150, 1'b0);
    endtask

    // Storage stalled: fill FIFO until a record is lost, then drain in order
    task automatic t_overrun();
        // One held update, sixteen queued and one in the slot; the next is lost
        for (int i = 0; i < 19; i++) begin
            rpsl_ctrl_model_inst.frame(4'(i), 2, 1'b0, -1);
        end
        repeat (20) @(negedge clk_in);
        chk_val("overrun_out", 16'h0001, overrun_out);
        for (int i = 0; i < 18; i++) begin
            get_stat(4'(i), 1, 2, 1'b0);
        end
        stat_ready_in = 1'b1;
        repeat (40) @(negedge clk_in);
        stat_ready_in = 1'b0;
        chk_val("stat_valid_out", 16'h0000, stat_valid_out);
    endtask

    // Reset needs link edges too, so the link clock runs during it
    initial begin
        resetn_in = 1'b0;
        mgmt_mode_in = 1'b0;
        stat_ready_in = 1'b0;
        fork
            repeat (8) @(negedge clk_in);
            rpsl_ctrl_model_inst.idle(3);
        join
        resetn_in = 1'b1;
        mgmt_mode_in = 1'b1;
        rpsl_ctrl_model_inst.idle(4);
        t_reset();
        t_classify();
        t_mode();
        t_overrun();
        close_out();
    end
endmodule
